// File: hdl/fcd_pkg.sv
/*
 * Shared constants and types of the flash command decoder: command codes,
 * register offsets, status word bit positions, reset values, timing.
 * Assumes a 200 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package fcd_pkg;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_CLEAR = 8'h50;
	localparam logic [7:0] CMD_PROG = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT = 8'h10;
	localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_FACTORY_BURST_PROGRAMMING = 8'h80;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK = 8'h01;
	localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
	localparam logic [7:0] CMD_OTP = 8'hC0;
	localparam logic [7:0] CMD_SET_RCR = 8'h03;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;

	localparam logic [7:0] OFS_CMD_ADDR = 8'h00;
	localparam logic [7:0] OFS_CMD_DATA = 8'h04;
	localparam logic [7:0] OFS_READ_DATA = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;
	localparam logic [7:0] OFS_RCR = 8'h10;

	localparam int SR_READY = 7;
	localparam int SR_ESUSP = 6;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_PROG_ERR = 4;
	localparam int SR_VPP = 3;
	localparam int SR_PSUSP = 2;
	localparam int SR_LOCKED = 1;
	localparam int SR_FACTORY_BURST_PROGRAMMING = 0;
	localparam int RCR_SYNC = 15;

	localparam logic [15:0] RCR_RST = 16'h0000;
	localparam logic [7:0] SNAP_RST = 8'h80;
	localparam logic LOCK_RST = 1'h0;
	localparam logic [3:0] PIN_IDLE = 4'h7;

	localparam int BLK_LO = 17;
	localparam int BLK_W = 4;
	localparam int BLOCKS = 16;
	localparam int BUF_AW = 5;
	localparam int BUF_WORDS = 32;

	localparam int CLK_PERIOD_NS = 5;
	localparam int OP_TIME_NS = 100;
	localparam logic [7:0] OP_CYCLES =
		8'((OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [7:0] ID_LOCK_OFS = 8'h02;
	localparam logic [7:0] ID_RCR_OFS = 8'h05;
	localparam logic [7:0] QRY_OFS = 8'h10;
	localparam logic [23:0] QRY_TEXT = 24'h515259;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		RD_ARRAY = 2'b00,
		RD_STATUS = 2'b01,
		RD_ID = 2'b10,
		RD_QUERY = 2'b11
	} fcd_rmode_e;

	typedef enum logic [2:0] {
		P_NONE = 3'b000,
		P_PROG = 3'b001,
		P_ERASE = 3'b010,
		P_BUFCNT = 3'b011,
		P_BUFDATA = 3'b100,
		P_FACTORY_BURST_PROGRAMMING = 3'b101,
		P_LOCK = 3'b110,
		P_OTP = 3'b111
	} fcd_pend_e;

	typedef enum logic [2:0] {
		W_IDLE = 3'b000,
		W_PROG = 3'b001,
		W_ERASE = 3'b010,
		W_BUFPROG = 3'b011,
		W_OTP = 3'b100,
		W_FACTORY_BURST_PROGRAMMING = 3'b101,
		W_PSUSP = 3'b110,
		W_ESUSP = 3'b111
	} fcd_wsm_e;
endpackage

// File: hdl/fcd_buf_mem.sv
/*
 * Program buffer of the flash command decoder: 32 words of 16 bits,
 * one write port, registered read data.
 * Assumes writer and reader share aclk.
 */
`timescale 1ns/10ps
module fcd_buf_mem (
	input logic aclk,
	input logic wr_en,
	input logic [fcd_pkg::BUF_AW-1:0] wr_addr,
	input logic [15:0] wr_data,
	input logic [fcd_pkg::BUF_AW-1:0] rd_addr,
	output logic [15:0] rd_data
);
	logic [15:0] mem [fcd_pkg::BUF_WORDS];

	always_ff @(posedge aclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	always_ff @(posedge aclk)
	begin
		rd_data <= mem[rd_addr];
	end
endmodule

// File: hdl/fcd_decoder.sv
/*
 * Flash command decoder: takes command cycles over AXI4-Lite, runs the
 * write state machine, keeps status word, lock table and read config.
 * Assumes pins ce_n, oe_n, address_valid_n, vpp_low are asynchronous;
 * arr_rdata and op_fail come from array logic on aclk.
 */
`timescale 1ns/10ps
module fcd_decoder (
	input logic aclk,
	input logic aresetn,
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic ce_n,
	input logic oe_n,
	input logic address_valid_n,
	input logic vpp_low,
	input logic [15:0] arr_rdata,
	input logic op_fail,
	output logic arr_we,
	output logic arr_erase,
	output logic arr_otp,
	output logic [23:0] arr_addr,
	output logic [15:0] arr_wdata
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [23:0] cmd_addr_q;
	logic [15:0] rcr_q;
	logic [7:0] err_q, err_set, snap_q, status_live;
	logic [3:0] pin_s1_q, pin_s2_q, pin_prev_q, fall;
	logic wr_go, cmd_fire, toggle, vpp_s, busy, start, done;
	logic [7:0] cd;
	logic [31:0] rd_word;
	logic [15:0] read_val, id_val;
	logic [7:0] qry;
	fcd_pkg::fcd_pend_e pend_q, pend_d;
	fcd_pkg::fcd_rmode_e rmode_q, rmode_d;
	fcd_pkg::fcd_wsm_e wsm_q, susp_from_q, go_kind;
	logic go, seq_err, clr_err, lk_set, lk_down, lk_clr, rcr_ld;
	logic buf_wr, susp, resume, factory_burst_programming_wr, factory_burst_programming_exit, lk_abort;
	logic [fcd_pkg::BLOCKS-1:0] locked_q, down_q;
	logic [fcd_pkg::BLK_W-1:0] blk;
	logic [5:0] left_q, idx_q;
	logic [4:0] last_q, wr_idx_q, rd_idx_q;
	logic rd_pend_q;
	logic [7:0] cnt_q;
	logic [23:0] op_addr_q;
	logic [15:0] buf_rdata;

	function automatic logic mapped(input logic [7:0] a);
		return a == fcd_pkg::OFS_CMD_ADDR || a == fcd_pkg::OFS_CMD_DATA ||
			a == fcd_pkg::OFS_READ_DATA || a == fcd_pkg::OFS_STATE ||
			a == fcd_pkg::OFS_RCR;
	endfunction

	// ***********************************************
	// AXI4-Lite write channel
	// ***********************************************
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign cmd_fire = wr_go && awaddr_q == fcd_pkg::OFS_CMD_DATA;
	assign cd = wdata_q[7:0];
	assign blk = cmd_addr_q[fcd_pkg::BLK_LO +: fcd_pkg::BLK_W];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'h1;
			s_axi_wready <= 1'h1;
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= fcd_pkg::RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'h0;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'h0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'h1;
				s_axi_bresp <= mapped(awaddr_q) ? fcd_pkg::RESP_OKAY :
					fcd_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'h0;
				s_axi_awready <= 1'h1;
				s_axi_wready <= 1'h1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cmd_addr_q <= 24'h000000;
		else if (wr_go && awaddr_q == fcd_pkg::OFS_CMD_ADDR)
			for (int i = 0; i < 3; i++)
				if (wstrb_q[i])
					cmd_addr_q[8*i +: 8] <= wdata_q[8*i +: 8];
	end

	// ***********************************************
	// AXI4-Lite read channel
	// ***********************************************
	always_comb
	begin
		id_val = 16'h0000;
		if (cmd_addr_q[7:0] == fcd_pkg::ID_RCR_OFS)
			id_val = rcr_q;
		else if (cmd_addr_q[7:0] == fcd_pkg::ID_LOCK_OFS)
			id_val = {14'h0000, down_q[blk], locked_q[blk]};
		case (cmd_addr_q[7:0])
			fcd_pkg::QRY_OFS: qry = fcd_pkg::QRY_TEXT[23:16];
			fcd_pkg::QRY_OFS + 8'h01: qry = fcd_pkg::QRY_TEXT[15:8];
			fcd_pkg::QRY_OFS + 8'h02: qry = fcd_pkg::QRY_TEXT[7:0];
			default: qry = 8'h00;
		endcase
		unique case (rmode_q)
			fcd_pkg::RD_ARRAY: read_val = arr_rdata;
			fcd_pkg::RD_STATUS: read_val = {8'h00, snap_q};
			fcd_pkg::RD_ID: read_val = id_val;
			fcd_pkg::RD_QUERY: read_val = {8'h00, qry};
		endcase
		case (s_axi_araddr)
			fcd_pkg::OFS_CMD_ADDR: rd_word = {8'h00, cmd_addr_q};
			fcd_pkg::OFS_READ_DATA: rd_word = {16'h0000, read_val};
			fcd_pkg::OFS_STATE: rd_word = {14'h0000, rmode_q, 1'h0, pend_q,
				1'h0, wsm_q, status_live};
			fcd_pkg::OFS_RCR: rd_word = {16'h0000, rcr_q};
			default: rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid <= 1'h0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= fcd_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'h0;
				s_axi_rvalid <= 1'h1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= mapped(s_axi_araddr) ? fcd_pkg::RESP_OKAY :
					fcd_pkg::RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'h0;
				s_axi_arready <= 1'h1;
			end
		end
	end

	// ***********************************************
	// Pin synchronisers and status word snapshot
	// ***********************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_s1_q <= fcd_pkg::PIN_IDLE;
			pin_s2_q <= fcd_pkg::PIN_IDLE;
			pin_prev_q <= fcd_pkg::PIN_IDLE;
		end
		else
		begin
			pin_s1_q <= {vpp_low, address_valid_n, oe_n, ce_n};
			pin_s2_q <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	assign fall = pin_prev_q & ~pin_s2_q;
	assign vpp_s = pin_s2_q[3];
	assign toggle = fall[0] | (rcr_q[fcd_pkg::RCR_SYNC] ? fall[2] : fall[1]);
	assign busy = wsm_q inside {fcd_pkg::W_PROG, fcd_pkg::W_ERASE,
		fcd_pkg::W_BUFPROG, fcd_pkg::W_OTP, fcd_pkg::W_FACTORY_BURST_PROGRAMMING};

	always_comb
	begin
		status_live = err_q;
		status_live[fcd_pkg::SR_READY] = !busy;
		status_live[fcd_pkg::SR_ESUSP] = wsm_q == fcd_pkg::W_ESUSP;
		status_live[fcd_pkg::SR_PSUSP] = wsm_q == fcd_pkg::W_PSUSP;
		status_live[fcd_pkg::SR_FACTORY_BURST_PROGRAMMING] = wsm_q == fcd_pkg::W_FACTORY_BURST_PROGRAMMING;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			snap_q <= fcd_pkg::SNAP_RST;
		else if (toggle)
			snap_q <= status_live;
	end

	chk_status_snap: assert property (toggle |=> snap_q == $past(status_live))
		else $error("status snapshot not refreshed on toggle");

	// ***********************************************
	// Command decode
	// ***********************************************
	always_comb
	begin
		pend_d = pend_q;
		rmode_d = rmode_q;
		go = 1'h0;
		go_kind = fcd_pkg::W_PROG;
		{seq_err, clr_err, lk_set, lk_down, lk_clr, rcr_ld} = 6'h00;
		{buf_wr, susp, resume, factory_burst_programming_wr, factory_burst_programming_exit, lk_abort} = 6'h00;
		if (cmd_fire)
		begin
			unique case (pend_q)
				fcd_pkg::P_PROG, fcd_pkg::P_ERASE, fcd_pkg::P_FACTORY_BURST_PROGRAMMING,
				fcd_pkg::P_OTP:
				begin
					pend_d = fcd_pkg::P_NONE;
					rmode_d = fcd_pkg::RD_STATUS;
					if (pend_q == fcd_pkg::P_OTP)
						go = 1'h1;
					else if (pend_q != fcd_pkg::P_PROG && cd != fcd_pkg::CMD_CONFIRM)
						seq_err = 1'h1;
					else if (pend_q == fcd_pkg::P_FACTORY_BURST_PROGRAMMING)
						go = 1'h1;
					else if (locked_q[blk])
						lk_abort = 1'h1;
					else
						go = 1'h1;
					go_kind = pend_q == fcd_pkg::P_OTP ? fcd_pkg::W_OTP :
						pend_q == fcd_pkg::P_FACTORY_BURST_PROGRAMMING ? fcd_pkg::W_FACTORY_BURST_PROGRAMMING :
						pend_q == fcd_pkg::P_ERASE ? fcd_pkg::W_ERASE :
						fcd_pkg::W_PROG;
				end
				fcd_pkg::P_BUFCNT:
					pend_d = fcd_pkg::P_BUFDATA;
				fcd_pkg::P_BUFDATA:
				begin
					if (left_q != 6'h00)
						buf_wr = 1'h1;
					else
					begin
						pend_d = fcd_pkg::P_NONE;
						go_kind = fcd_pkg::W_BUFPROG;
						if (cd != fcd_pkg::CMD_CONFIRM)
							seq_err = 1'h1;
						else if (locked_q[blk])
							lk_abort = 1'h1;
						else
							go = 1'h1;
					end
				end
				fcd_pkg::P_LOCK:
				begin
					pend_d = fcd_pkg::P_NONE;
					rmode_d = fcd_pkg::RD_STATUS;
					case (cd)
						fcd_pkg::CMD_LOCK: lk_set = 1'h1;
						fcd_pkg::CMD_LOCKDOWN: lk_down = 1'h1;
						fcd_pkg::CMD_CONFIRM: lk_clr = !down_q[blk];
						fcd_pkg::CMD_SET_RCR:
						begin
							rcr_ld = 1'h1;
							rmode_d = fcd_pkg::RD_ARRAY;
						end
						default: seq_err = 1'h1;
					endcase
				end
				fcd_pkg::P_NONE:
				begin
					if (wsm_q == fcd_pkg::W_FACTORY_BURST_PROGRAMMING)
					begin
						factory_burst_programming_wr = blk == op_addr_q[fcd_pkg::BLK_LO +: fcd_pkg::BLK_W];
						factory_burst_programming_exit = !factory_burst_programming_wr;
					end
					else if (busy)
					begin
						if (cd == fcd_pkg::CMD_READ_STATUS)
							rmode_d = fcd_pkg::RD_STATUS;
						susp = cd == fcd_pkg::CMD_SUSPEND &&
							wsm_q != fcd_pkg::W_OTP;
					end
					else
						case (cd)
							fcd_pkg::CMD_READ_ARRAY: rmode_d = fcd_pkg::RD_ARRAY;
							fcd_pkg::CMD_READ_STATUS: rmode_d = fcd_pkg::RD_STATUS;
							fcd_pkg::CMD_READ_ID: rmode_d = fcd_pkg::RD_ID;
							fcd_pkg::CMD_QUERY: rmode_d = fcd_pkg::RD_QUERY;
							fcd_pkg::CMD_CLEAR: clr_err = 1'h1;
							fcd_pkg::CMD_CONFIRM: resume = wsm_q != fcd_pkg::W_IDLE;
							fcd_pkg::CMD_LOCK_SETUP: pend_d = fcd_pkg::P_LOCK;
							default:
								if (wsm_q == fcd_pkg::W_IDLE)
								begin
									if (cd == fcd_pkg::CMD_PROG || cd == fcd_pkg::CMD_PROG_ALT)
										pend_d = fcd_pkg::P_PROG;
									else if (cd == fcd_pkg::CMD_BUF_PROG)
										pend_d = fcd_pkg::P_BUFCNT;
									else if (cd == fcd_pkg::CMD_FACTORY_BURST_PROGRAMMING)
										pend_d = fcd_pkg::P_FACTORY_BURST_PROGRAMMING;
									else if (cd == fcd_pkg::CMD_ERASE)
										pend_d = fcd_pkg::P_ERASE;
									else if (cd == fcd_pkg::CMD_OTP)
										pend_d = fcd_pkg::P_OTP;
								end
						endcase
				end
			endcase
		end
	end

	assign start = go && !vpp_s;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pend_q <= fcd_pkg::P_NONE;
			rmode_q <= fcd_pkg::RD_ARRAY;
		end
		else
		begin
			pend_q <= pend_d;
			rmode_q <= rmode_d;
		end
	end

	chk_query_enter: assert property (cmd_fire && pend_q == fcd_pkg::P_NONE &&
		cd == fcd_pkg::CMD_QUERY && wsm_q == fcd_pkg::W_IDLE
		|=> rmode_q == fcd_pkg::RD_QUERY)
		else $error("query code did not select query reads");
	chk_busy_ignore: assert property (wsm_q == fcd_pkg::W_PROG && cmd_fire &&
		cd != fcd_pkg::CMD_READ_STATUS && cd != fcd_pkg::CMD_SUSPEND && !done
		|=> wsm_q == fcd_pkg::W_PROG && $stable(rmode_q) &&
		pend_q == fcd_pkg::P_NONE)
		else $error("command accepted while programming");
	chk_erase_seq: assert property (cmd_fire && pend_q == fcd_pkg::P_ERASE &&
		cd != fcd_pkg::CMD_CONFIRM |=> err_q[fcd_pkg::SR_ERASE_ERR] &&
		err_q[fcd_pkg::SR_PROG_ERR] && rmode_q == fcd_pkg::RD_STATUS)
		else $error("bad erase confirm not flagged");

	// ***********************************************
	// Error bits, lock table, read configuration
	// ***********************************************
	always_comb
	begin
		err_set = 8'h00;
		if (seq_err)
			{err_set[fcd_pkg::SR_ERASE_ERR], err_set[fcd_pkg::SR_PROG_ERR]} = 2'h3;
		if (lk_abort)
			err_set[fcd_pkg::SR_LOCKED] = 1'h1;
		if (go && vpp_s)
			err_set[fcd_pkg::SR_VPP] = 1'h1;
		if (lk_abort || (go && vpp_s))
			err_set[go_kind == fcd_pkg::W_ERASE ? fcd_pkg::SR_ERASE_ERR :
				fcd_pkg::SR_PROG_ERR] = 1'h1;
		if (done && op_fail)
			err_set[wsm_q == fcd_pkg::W_ERASE ? fcd_pkg::SR_ERASE_ERR :
				fcd_pkg::SR_PROG_ERR] = 1'h1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			err_q <= 8'h00;
		else
			err_q <= (clr_err ? 8'h00 : err_q) | err_set;
	end

	chk_clear_err: assert property (cmd_fire && pend_q == fcd_pkg::P_NONE &&
		cd == fcd_pkg::CMD_CLEAR && !busy && err_set == 8'h00 |=> err_q == 8'h00)
		else $error("clear command left error bits");

	for (genvar b = 0; b < fcd_pkg::BLOCKS; b++)
	begin : g_lock
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				locked_q[b] <= fcd_pkg::LOCK_RST;
				down_q[b] <= 1'h0;
			end
			else if (blk == b)
			begin
				if (lk_set || lk_down)
					locked_q[b] <= 1'h1;
				else if (lk_clr)
					locked_q[b] <= 1'h0;
				if (lk_down)
					down_q[b] <= 1'h1;
			end
		end
	end

	chk_unlock_down: assert property (cmd_fire && pend_q == fcd_pkg::P_LOCK &&
		cd == fcd_pkg::CMD_CONFIRM && down_q[blk] |=> locked_q[blk])
		else $error("locked-down block was unlocked");

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rcr_q <= fcd_pkg::RCR_RST;
		else if (rcr_ld)
			rcr_q <= cmd_addr_q[15:0];
	end

	chk_rcr_load: assert property (cmd_fire && pend_q == fcd_pkg::P_LOCK &&
		cd == fcd_pkg::CMD_SET_RCR |=> rcr_q == cmd_addr_q[15:0] &&
		rmode_q == fcd_pkg::RD_ARRAY)
		else $error("read config not loaded from address");

	// ***********************************************
	// Write state machine and program buffer
	// ***********************************************
	assign done = (wsm_q inside {fcd_pkg::W_PROG, fcd_pkg::W_ERASE,
		fcd_pkg::W_OTP} && cnt_q == 8'h00 && !susp) ||
		(wsm_q == fcd_pkg::W_BUFPROG && idx_q > {1'h0, last_q} &&
		!rd_pend_q && !susp);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wsm_q <= fcd_pkg::W_IDLE;
			susp_from_q <= fcd_pkg::W_IDLE;
			cnt_q <= 8'h00;
			idx_q <= 6'h00;
		end
		else
			unique case (wsm_q)
				fcd_pkg::W_IDLE:
					if (start)
					begin
						wsm_q <= go_kind;
						cnt_q <= fcd_pkg::OP_CYCLES;
						idx_q <= 6'h00;
					end
				fcd_pkg::W_PROG, fcd_pkg::W_ERASE, fcd_pkg::W_OTP,
				fcd_pkg::W_BUFPROG:
					if (susp)
					begin
						wsm_q <= wsm_q == fcd_pkg::W_ERASE ? fcd_pkg::W_ESUSP :
							fcd_pkg::W_PSUSP;
						susp_from_q <= wsm_q;
					end
					else if (done)
						wsm_q <= fcd_pkg::W_IDLE;
					else
					begin
						if (cnt_q != 8'h00)
							cnt_q <= cnt_q - 8'h01;
						if (idx_q <= {1'h0, last_q})
							idx_q <= idx_q + 6'h01;
					end
				fcd_pkg::W_FACTORY_BURST_PROGRAMMING:
					if (factory_burst_programming_exit)
						wsm_q <= fcd_pkg::W_IDLE;
				fcd_pkg::W_PSUSP, fcd_pkg::W_ESUSP:
					if (resume)
						wsm_q <= susp_from_q;
			endcase
	end

	chk_suspend_flag: assert property (wsm_q == fcd_pkg::W_ERASE && cmd_fire &&
		pend_q == fcd_pkg::P_NONE && cd == fcd_pkg::CMD_SUSPEND
		|=> status_live[fcd_pkg::SR_ESUSP] && status_live[fcd_pkg::SR_READY])
		else $error("erase suspend not shown in status");
	chk_suspend_hold: assert property (wsm_q == fcd_pkg::W_PSUSP && !resume
		|=> wsm_q == fcd_pkg::W_PSUSP)
		else $error("program suspend left without resume");

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			left_q <= 6'h00;
			last_q <= 5'h00;
			wr_idx_q <= 5'h00;
			op_addr_q <= 24'h000000;
			rd_pend_q <= 1'h0;
			rd_idx_q <= 5'h00;
		end
		else
		begin
			if (cmd_fire && pend_q == fcd_pkg::P_BUFCNT)
			begin
				left_q <= {1'h0, cd[4:0]} + 6'h01;
				last_q <= cd[4:0];
				wr_idx_q <= 5'h00;
			end
			else if (buf_wr)
			begin
				left_q <= left_q - 6'h01;
				wr_idx_q <= wr_idx_q + 5'h01;
			end
			if (buf_wr && wr_idx_q == 5'h00)
				op_addr_q <= cmd_addr_q;
			else if (start && go_kind != fcd_pkg::W_BUFPROG)
				op_addr_q <= cmd_addr_q;
			rd_pend_q <= wsm_q == fcd_pkg::W_BUFPROG && !susp &&
				idx_q <= {1'h0, last_q};
			rd_idx_q <= idx_q[4:0];
		end
	end

	fcd_buf_mem u_buf (
		.aclk(aclk),
		.wr_en(buf_wr),
		.wr_addr(wr_idx_q),
		.wr_data(wdata_q[15:0]),
		.rd_addr(idx_q[4:0]),
		.rd_data(buf_rdata)
	);

	// ***********************************************
	// Array strobes
	// ***********************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arr_we <= 1'h0;
			arr_erase <= 1'h0;
			arr_otp <= 1'h0;
			arr_addr <= 24'h000000;
			arr_wdata <= 16'h0000;
		end
		else
		begin
			arr_we <= (start && go_kind == fcd_pkg::W_PROG) || factory_burst_programming_wr ||
				rd_pend_q;
			arr_erase <= start && go_kind == fcd_pkg::W_ERASE;
			arr_otp <= start && go_kind == fcd_pkg::W_OTP;
			arr_addr <= cmd_addr_q;
			if (start || factory_burst_programming_wr)
				arr_wdata <= wdata_q[15:0];
			if (rd_pend_q)
			begin
				arr_addr <= op_addr_q + {19'h00000, rd_idx_q};
				arr_wdata <= buf_rdata;
			end
		end
	end

	chk_prog_start: assert property (cmd_fire && pend_q == fcd_pkg::P_PROG &&
		!locked_q[blk] && !vpp_s |=> arr_we && wsm_q == fcd_pkg::W_PROG &&
		arr_addr == $past(cmd_addr_q) ##1 !arr_we)
		else $error("program word not started");
	chk_buf_copy: assert property (rd_pend_q |=> arr_we)
		else $error("buffered word not written to array");
endmodule

// File: test/fcd_array_model.sv
/*
 * Array model behind the command decoder: read data follows the address,
 * failure flag on request.
 * Assumes it shares aclk with the decoder.
 */
`timescale 1ns/10ps
module fcd_array_model (
	input wire logic aclk,
	input wire logic [23:0] arr_addr,
	input wire logic fail_req,
	output logic [15:0] arr_rdata,
	output logic op_fail
);
	always_ff @(posedge aclk)
	begin
		arr_rdata <= arr_addr[15:0] ^ 16'hA5A5;
		op_fail <= fail_req;
	end
endmodule

// File: test/testbench.sv
/*
 * Self-checking bench of the command decoder over AXI4-Lite.
 * Assumes fcd_pkg, fcd_decoder and fcd_array_model are compiled first.
 */
`timescale 1ns/10ps
module testbench;
	typedef struct {logic [7:0] c; logic [1:0] m;} fcd_row_s;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, got;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
	logic s_axi_arvalid = 0, s_axi_rready = 1, fail_req = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, arr_we, arr_erase, arr_otp, op_fail;
	logic [1:0] s_axi_bresp, s_axi_rresp, gresp;
	logic ce_n = 1, oe_n = 1, address_valid_n = 1, vpp_low = 0;
	logic [15:0] arr_rdata, arr_wdata;
	logic [23:0] arr_addr;
	int errors = 0;
	int n_checks = 0;
	int n_we = 0, n_er = 0, n_otp = 0;
	logic [23:0] we_addr = 0;
	logic [15:0] we_data = 0;
	fcd_row_s rows [4] = '{'{8'h70, 2'h1}, '{8'h90, 2'h2},
		'{8'h98, 2'h3}, '{8'hFF, 2'h0}};

	fcd_decoder fcd_decoder_i (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ce_n,
		.oe_n, .address_valid_n, .vpp_low, .arr_rdata, .op_fail, .arr_we,
		.arr_erase, .arr_otp, .arr_addr, .arr_wdata);
	fcd_array_model fcd_array_model_i (.aclk, .arr_addr, .fail_req,
		.arr_rdata, .op_fail);

	initial
	begin
		forever #2.5 aclk = ~aclk;
	end

	// Counts array strobes and keeps the last word written
	always @(posedge aclk)
	begin
		if (arr_we)
		begin
			n_we <= n_we + 1;
			we_addr <= arr_addr;
			we_data <= arr_wdata;
		end
		n_er <= n_er + int'(arr_erase);
		n_otp <= n_otp + int'(arr_otp);
	end

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	// Address and data released each on its own ready
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			gresp = s_axi_bresp;
			if (s_axi_bvalid)
				break;
		end
		if (i == 100)
		begin
			errors++;
			tally_and_finish();
		end
	endtask

	task automatic rd(input logic [7:0] a);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
			got = s_axi_rdata;
			gresp = s_axi_rresp;
			if (s_axi_rvalid)
				break;
		end
		if (i == 100)
		begin
			errors++;
			tally_and_finish();
		end
	endtask

	task automatic code(input logic [15:0] d);
		wr(fcd_pkg::OFS_CMD_DATA, 32'(d));
	endtask

	task automatic cmd(input logic [23:0] a, input logic [15:0] d);
		wr(fcd_pkg::OFS_CMD_ADDR, 32'(a));
		code(d);
	endtask

	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(fcd_pkg::OFS_STATE);
		chk("state", 32'h80, got);
		foreach (rows[i])
		begin
			cmd(24'h10, 16'(rows[i].c));
			rd(fcd_pkg::OFS_STATE);
			chk("mode", 32'(rows[i].m), 32'(got[17:16]));
		end
		code(16'h98);
		rd(fcd_pkg::OFS_READ_DATA);
		chk("query", 32'h51, got);
		code(16'h20);
		code(16'hFF);
		rd(fcd_pkg::OFS_STATE);
		chk("seq", 32'h100B0, got);
		rd(fcd_pkg::OFS_READ_DATA);
		chk("stale", 32'h80, got);
		ce_n <= 0;
		repeat (6) @(posedge aclk);
		ce_n <= 1;
		rd(fcd_pkg::OFS_READ_DATA);
		chk("fresh", 32'hB0, got);
		code(16'h50);
		rd(fcd_pkg::OFS_STATE);
		chk("clear", 32'h80, 32'(got[7:0]));
		cmd(24'h100, 16'h10);
		code(16'h1234);
		code(16'hB0);
		chk("wdata", 32'h1234, 32'(arr_wdata));
		rd(fcd_pkg::OFS_STATE);
		chk("susp", 32'h684, 32'(got[10:0]));
		code(16'hFF);
		rd(fcd_pkg::OFS_STATE);
		chk("hold", 32'h6, 32'(got[10:8]));
		code(16'hD0);
		code(16'h20);
		rd(fcd_pkg::OFS_STATE);
		chk("busy", 32'h01, 32'(got[14:8]));
		chk("ready", 32'h00, 32'(got[7:0]));
		repeat (40) @(posedge aclk);
		cmd(24'h020002, 16'h60);
		code(16'h01);
		code(16'h90);
		rd(fcd_pkg::OFS_READ_DATA);
		chk("lock", 32'h1, got);
		code(16'h60);
		code(16'h2F);
		code(16'h60);
		code(16'hD0);
		code(16'h90);
		rd(fcd_pkg::OFS_READ_DATA);
		chk("down", 32'h3, got);
		code(16'h20);
		code(16'hD0);
		rd(fcd_pkg::OFS_STATE);
		chk("abort", 32'hA2, 32'(got[7:0]));
		code(16'h50);
		cmd(24'h1234, 16'h60);
		code(16'h03);
		rd(fcd_pkg::OFS_RCR);
		chk("rcr", 32'h1234, got);
		rd(fcd_pkg::OFS_STATE);
		chk("amode", 32'h0, 32'(got[17:16]));
		code(16'h60);
		code(16'h77);
		rd(fcd_pkg::OFS_STATE);
		chk("lseq", 32'hB0, 32'(got[7:0]));
		code(16'h50);
		cmd(24'h040000, 16'h20);
		code(16'hD0);
		code(16'hB0);
		rd(fcd_pkg::OFS_STATE);
		chk("esusp", 32'h7C0, 32'(got[10:0]));
		code(16'hD0);
		code(16'hFF);
		rd(fcd_pkg::OFS_STATE);
		chk("emode", 32'h1, 32'(got[17:16]));
		repeat (40) @(posedge aclk);
		chk("erase", 32'h1, 32'(n_er));
		code(16'hC0);
		code(16'h5A5A);
		repeat (40) @(posedge aclk);
		chk("otp", 32'h1, 32'(n_otp));
		chk("pdata", 32'h5A5A, 32'(arr_wdata));
		fail_req <= 1;
		code(16'h40);
		code(16'h0BEE);
		repeat (40) @(posedge aclk);
		rd(fcd_pkg::OFS_STATE);
		chk("pfail", 32'h90, 32'(got[7:0]));
		chk("pword", 32'h0BEE, 32'(we_data));
		fail_req <= 0;
		code(16'h50);
		vpp_low <= 1;
		repeat (4) @(posedge aclk);
		code(16'h20);
		code(16'hD0);
		rd(fcd_pkg::OFS_STATE);
		chk("vpp", 32'hA8, 32'(got[7:0]));
		vpp_low <= 0;
		code(16'h50);
		code(16'hE8);
		code(16'h0001);
		cmd(24'h040010, 16'h1111);
		code(16'h2222);
		code(16'hD0);
		repeat (40) @(posedge aclk);
		chk("bwords", 32'h4, 32'(n_we));
		chk("baddr", 32'h040011, 32'(we_addr));
		chk("bdata", 32'h2222, 32'(we_data));
		code(16'h80);
		code(16'hD0);
		code(16'h3333);
		rd(fcd_pkg::OFS_STATE);
		chk("factory_burst_programming", 32'h501, 32'(got[10:0]));
		chk("fword", 32'h3333, 32'(we_data));
		cmd(24'h000000, 16'hFF);
		code(16'hFF);
		rd(fcd_pkg::OFS_READ_DATA);
		chk("array", 32'hA5A5, got);
		wr(8'h44, 32'h0);
		chk("bresp", 32'(fcd_pkg::RESP_SLVERR), 32'(gresp));
		rd(8'h40);
		chk("resp", 32'(fcd_pkg::RESP_SLVERR), 32'(gresp));
		tally_and_finish();
	end
endmodule
